// *** pwm_pkg.sv ***
package pwm_pkg;

  // Timing figures
  localparam int unsigned OSC_PERIOD_NS   = 10;
  localparam int unsigned OSC_PER_INSTR   = 4;

  // Prescale select codes
  localparam logic [1:0] PRESCALE_1      = 2'h0;
  localparam logic [1:0] PRESCALE_4      = 2'h1;
  localparam logic [1:0] PRESCALE_16     = 2'h2;

  // Last fine phase of one timebase increment for each ratio
  localparam logic [5:0] FINE_TOP_1      = 6'h03;
  localparam logic [5:0] FINE_TOP_4      = 6'h0F;
  localparam logic [5:0] FINE_TOP_16     = 6'h3F;

  // Reset values
  localparam logic [7:0] PERIOD_RESET    = 8'hFF;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [9:0] DUTY_RESET      = 10'h000;

  // Firmware-side settings
  typedef struct packed {
    logic       enable;
    logic [1:0] prescale_sel;
    logic [7:0] period_limit;
    logic [7:0] duty_buffer_high;
    logic [1:0] duty_buffer_low;
  } pwm_cfg_s;

  // Core state
  typedef struct packed {
    logic [7:0] timebase_count;
    logic [5:0] fine;
    logic [7:0] duty_active_high;
    logic [1:0] duty_active_low;
    logic       pwm_out;
    logic       period_match;
  } pwm_state_s;

endpackage : pwm_pkg

// *** pwm_fine_div.sv ***
`timescale 1ns/100ps
`default_nettype none
// Fine divider: four oscillator phases per instruction cycle, times the prescale
module pwm_fine_div (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [1:0] prescale_sel,
  output logic [5:0]      fine,
  output logic            tick
);

  logic [5:0] fine_r;
  logic [5:0] fine_nxt;
  logic [5:0] top;

  // Last fine step of one timebase increment; codes 2 and 3 both give 1:16
  always_comb begin
    case (prescale_sel)
      pwm_pkg::PRESCALE_1: top = pwm_pkg::FINE_TOP_1;
      pwm_pkg::PRESCALE_4: top = pwm_pkg::FINE_TOP_4;
      default:             top = pwm_pkg::FINE_TOP_16;
    endcase
    fine_nxt = 6'h00;
    if (run && fine_r != top) begin
      fine_nxt = fine_r + 6'h01;
    end
  end

  // Fine phase register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fine_r <= 6'h00;
    end else begin
      fine_r <= fine_nxt;
    end
  end

  assign fine = fine_r;
  assign tick = run && (fine_r == top);

endmodule : pwm_fine_div
`default_nettype wire

// *** pwm_period_duty_core.sv ***
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Period is (limit+1)*4*Tosc*prescale
// - Count equal limit clears on next increment
// - Match sets output unless duty zero
// - Match copies buffered duty into active
// - Duty is eight high plus two low
// - Buffered duty writable any time
// - Active duty not writable while running
// - High width is duty*Tosc*prescale
// - Ten-bit timebase from count plus phase
// - Timebase equal active duty clears output
// - Duty beyond period leaves output unchanged
// - Prescale ratios 1, 4 and 16
module pwm_period_duty_core (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire pwm_pkg::pwm_cfg_s cfg,
  output logic                   pwm_output_pin,
  output logic [7:0]             timebase_count,
  output logic [7:0]             duty_active_high,
  output logic                   period_start
);

  pwm_pkg::pwm_state_s st_r;
  pwm_pkg::pwm_state_s st_nxt;
  logic [5:0]          fine;
  logic                tick;
  logic                step;
  logic [9:0]          timebase_ahead;
  logic [1:0]          fine_low;
  logic [9:0]          timebase10;
  logic [9:0]          duty_active;
  logic [9:0]          duty_next;

  // Ten-bit timebase helper
  function automatic logic [9:0] join10(input logic [7:0] hi, input logic [1:0] lo);
    join10 = {hi, lo};
  endfunction : join10

  // Two low timebase bits for the selected prescale ratio
  function automatic logic [1:0] low_pair(input logic [1:0] sel, input logic [5:0] ph);
    case (sel)
      pwm_pkg::PRESCALE_1: low_pair = ph[1:0];
      pwm_pkg::PRESCALE_4: low_pair = ph[3:2];
      default:             low_pair = ph[5:4];
    endcase
  endfunction : low_pair

  // High when the phase bits below the low pair are at their last value
  function automatic logic pair_steps(input logic [1:0] sel, input logic [5:0] ph);
    case (sel)
      pwm_pkg::PRESCALE_1: pair_steps = 1'b1;
      pwm_pkg::PRESCALE_4: pair_steps = (ph[1:0] == 2'h3);
      default:             pair_steps = (ph[3:0] == 4'hF);
    endcase
  endfunction : pair_steps

  // Prescaler and oscillator phase, one increment per 4*prescale clocks
  pwm_fine_div u_div (
    .mclk         (mclk),
    .rstn         (rstn),
    .run          (cfg.enable),
    .prescale_sel (cfg.prescale_sel),
    .fine         (fine),
    .tick         (tick)
  );

  // Low timebase bits: system phase at 1:1, top prescaler bits otherwise
  assign fine_low    = low_pair(cfg.prescale_sel, fine);
  assign timebase10  = join10(st_r.timebase_count, fine_low);
  assign duty_active = join10(st_r.duty_active_high, st_r.duty_active_low);
  assign duty_next   = join10(cfg.duty_buffer_high, cfg.duty_buffer_low);
  assign step        = cfg.enable && pair_steps(cfg.prescale_sel, fine);
  assign timebase_ahead = timebase10 + 10'h001;

  // Next-state logic
  always_comb begin
    st_nxt              = st_r;
    st_nxt.fine         = fine;
    st_nxt.period_match = 1'b0;
    if (!cfg.enable) begin
      // Stopped: active duty may be loaded, output idles low
      st_nxt.timebase_count   = pwm_pkg::COUNT_RESET;
      st_nxt.duty_active_high = cfg.duty_buffer_high;
      st_nxt.duty_active_low  = cfg.duty_buffer_low;
      st_nxt.pwm_out          = 1'b0;
    end else begin
      // Pulse ends as the timebase steps onto the duty; a duty past the period never does
      if (step && timebase_ahead == duty_active) begin
        st_nxt.pwm_out = 1'b0;
      end
      if (tick) begin
        if (st_r.timebase_count == cfg.period_limit) begin
          st_nxt.timebase_count   = pwm_pkg::COUNT_RESET;
          st_nxt.duty_active_high = cfg.duty_buffer_high;
          st_nxt.duty_active_low  = cfg.duty_buffer_low;
          st_nxt.pwm_out          = (duty_next != pwm_pkg::DUTY_RESET);
          st_nxt.period_match     = 1'b1;
        end else begin
          st_nxt.timebase_count = st_r.timebase_count + 8'h01;
        end
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{timebase_count: pwm_pkg::COUNT_RESET, fine: 6'h00,
                duty_active_high: 8'h00, duty_active_low: 2'h0,
                pwm_out: 1'b0, period_match: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign pwm_output_pin   = st_r.pwm_out;
  assign timebase_count   = st_r.timebase_count;
  assign duty_active_high = st_r.duty_active_high;
  assign period_start     = st_r.period_match;

  // Checks
  // Period match: the tick that ends the last count of the period
  sequence s_match;
    cfg.enable && tick && st_r.timebase_count == cfg.period_limit;
  endsequence

  // Pulse end: a step onto the active duty that is not a period match
  sequence s_hit;
    step && timebase_ahead == duty_active
    && !(tick && st_r.timebase_count == cfg.period_limit);
  endsequence

  // A 1:1 timebase increment while running
  sequence s_tick_one;
    cfg.enable && tick && cfg.prescale_sel == pwm_pkg::PRESCALE_1;
  endsequence

  // Four more clocks of 1:1 running
  sequence s_run_one;
    (cfg.enable && cfg.prescale_sel == pwm_pkg::PRESCALE_1) [*4];
  endsequence

  // Timebase restarts after the period match
  a_count_clear: assert property (@(posedge mclk) disable iff (!rstn)
    s_match |=> timebase_count == 8'h00)
    else $error("count not cleared after period match");

  // Pin set at period start for a nonzero duty
  a_pin_set: assert property (@(posedge mclk) disable iff (!rstn)
    s_match ##0 (duty_next != 10'h000) |=> pwm_output_pin)
    else $error("pin not set at period start");

  // Zero duty keeps the pin low
  a_zero_duty: assert property (@(posedge mclk) disable iff (!rstn)
    s_match ##0 (duty_next == 10'h000) |=> !pwm_output_pin)
    else $error("pin set with zero duty");

  // Buffered duty moves to the active register at the match
  a_duty_load: assert property (@(posedge mclk) disable iff (!rstn)
    s_match |=> duty_active == $past(duty_next))
    else $error("duty not transferred at period match");

  // Active duty frozen inside a running period
  a_duty_hold: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && $past(cfg.enable) && !$past(st_r.period_match) && !period_start
    |-> $stable(duty_active_high))
    else $error("active duty changed mid period");

  // Pin stays low once the timebase sits on the duty
  a_pulse_end: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && timebase10 == duty_active && !tick |=> !pwm_output_pin)
    else $error("pin not cleared on duty compare");

  // Count steps by one on a tick that is not a match
  a_count_step: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && tick && st_r.timebase_count != cfg.period_limit
    |=> timebase_count == $past(timebase_count) + 8'h01)
    else $error("count did not step");

  // The only rising edge is the period start
  a_no_rise: assert property (@(posedge mclk) disable iff (!rstn)
    !period_start |-> !$rose(pwm_output_pin))
    else $error("pin rose outside period start");

  // Pin falls as the timebase steps onto the duty
  a_pulse_fall: assert property (@(posedge mclk) disable iff (!rstn)
    s_hit |=> !pwm_output_pin)
    else $error("pin not cleared when timebase reached duty");

  // Pin stays high until the duty compare or the next match
  a_pulse_hold: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && pwm_output_pin && !(step && timebase_ahead == duty_active)
    && !(tick && st_r.timebase_count == cfg.period_limit) |=> pwm_output_pin)
    else $error("pin fell before the duty compare");

  // Stopped core idles low with the count cleared
  a_idle_low: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg.enable |=> !pwm_output_pin && timebase_count == pwm_pkg::COUNT_RESET)
    else $error("stopped core not idle");

  // Stopped core lets the active duty follow the buffer
  a_idle_load: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg.enable |=> duty_active == $past(duty_next))
    else $error("active duty not loaded while stopped");

  // Count holds between ticks
  a_count_hold: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && !tick |=> $stable(timebase_count))
    else $error("count moved without a tick");

  // Period start lasts a single clock
  a_start_single: assert property (@(posedge mclk) disable iff (!rstn)
    period_start |=> !period_start)
    else $error("period start longer than one clock");

  // No tick in the three clocks after a 1:1 tick
  a_tick_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    s_tick_one |=> (!tick) [*3])
    else $error("tick too early at 1:1");

  // At 1:1 the next tick comes four clocks later
  a_tick_gap: assert property (@(posedge mclk) disable iff (!rstn)
    s_tick_one ##1 s_run_one |-> tick)
    else $error("tick missing at 1:1");

  // Fine phase advances by one between ticks
  a_fine_step: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && !tick |=> fine == $past(fine) + 6'h01)
    else $error("fine phase did not advance");

  // Ten-bit timebase holds between steps of its low pair
  a_low_hold: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.enable && !step
    |=> cfg.prescale_sel != $past(cfg.prescale_sel) || $stable(timebase10))
    else $error("timebase moved between steps");

  // Ten-bit timebase steps by one inside a period
  a_low_step: assert property (@(posedge mclk) disable iff (!rstn)
    step && !tick
    |=> cfg.prescale_sel != $past(cfg.prescale_sel)
        || timebase10 == $past(timebase10) + 10'h001)
    else $error("timebase did not step by one");

endmodule : pwm_period_duty_core
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic              mclk;
  logic              rstn;
  pwm_pkg::pwm_cfg_s cfg;
  logic              pwm_output_pin;
  logic [7:0]        timebase_count;
  logic [7:0]        duty_active_high;
  logic              period_start;
  int                fail_count = 0;
  int                checks     = 0;
  int                cycles     = 0;

  pwm_period_duty_core pwm_period_duty_core_i (
    .mclk             (mclk),
    .rstn             (rstn),
    .cfg              (cfg),
    .pwm_output_pin   (pwm_output_pin),
    .timebase_count   (timebase_count),
    .duty_active_high (duty_active_high),
    .period_start     (period_start)
  );

  // Clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic cmp_count(string what, int exp, int seen);
    checks++;
    if (exp != seen) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : cmp_count

  task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] seen);
    checks++;
    if (exp !== seen) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp_byte

  // Restart the core with a fresh setting
  task automatic set_cfg(logic [1:0] pre, logic [7:0] limit, logic [9:0] duty);
    cfg.enable = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    cfg.prescale_sel = pre;
    cfg.period_limit = limit;
    {cfg.duty_buffer_high, cfg.duty_buffer_low} = duty;
    cfg.enable = 1'b1;
  endtask : set_cfg

  // Time one period from start pulse to start pulse; rewrite duty inside it
  task automatic measure(int exp_per, int exp_high, logic [7:0] exp_act, logic [9:0] later);
    int n;
    int per;
    int hi;
    n = 0;
    per = 0;
    hi = 0;
    while (period_start !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    do begin
      if (pwm_output_pin === 1'b1) hi++;
      if (per == 0) cmp_byte("timebase_count", 8'h00, timebase_count);
      if (per == 1) {cfg.duty_buffer_high, cfg.duty_buffer_low} = later;
      if (per == 2) cmp_byte("duty_active_high", exp_act, duty_active_high);
      per++;
      @(posedge mclk);
      #1;
    end while (period_start !== 1'b1 && per < 5000);
    cmp_count("period", exp_per, per);
    cmp_count("high", exp_high, hi);
  endtask : measure

  // Main sequence
  initial begin
    rstn = 1'b0;
    cfg = '0;
    repeat (16) @(posedge mclk);
    #1;
    cmp_count("pin in reset", 0, int'(pwm_output_pin !== 1'b0));
    rstn = 1'b1;
    set_cfg(2'h0, 8'h00, 10'h002);
    measure(4, 2, 8'h00, 10'h002);
    set_cfg(2'h0, 8'h03, 10'h000);
    measure(16, 0, 8'h00, 10'h000);
    set_cfg(2'h1, 8'h02, 10'h005);
    measure(48, 20, 8'h01, 10'h005);
    set_cfg(2'h2, 8'h01, 10'h007);
    measure(128, 112, 8'h01, 10'h007);
    set_cfg(2'h3, 8'h01, 10'h008);
    measure(128, 128, 8'h02, 10'h008);
    set_cfg(2'h0, 8'h07, 10'h00A);
    measure(32, 10, 8'h02, 10'h014);
    measure(32, 20, 8'h05, 10'h014);
    set_cfg(2'h0, 8'h05, 10'h017);
    measure(24, 23, 8'h05, 10'h017);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
